// >>> common/scp_consts.vh
`ifndef SCP_CONSTS_VH
`define SCP_CONSTS_VH

// *****
// Register offsets
// *****
`define SCP_REG_CMD        8'h07
`define SCP_REG_MDIV       8'h08
`define SCP_REG_STRETCH    8'h19
`define SCP_REG_MOTOR      8'h45
`define SCP_REG_FF_LO      8'h48
`define SCP_REG_FF_HI      8'h49
`define SCP_REG_CNT_LO     8'h4A
`define SCP_REG_CNT_HI     8'h4B
`define SCP_REG_SENSE      8'h60
`define SCP_REG_TRAIL_LO   8'h61
`define SCP_REG_TRAIL_HI   8'h62
`define SCP_REG_MODE       8'h63
`define SCP_REG_LLEN_LO    8'h64
`define SCP_REG_LLEN_HI    8'h65
`define SCP_REG_MISC       8'h66
`define SCP_REG_STATUS     8'h70
`define SCP_REG_PPER_LO    8'h71
`define SCP_REG_PPER_HI    8'h72

// *****
// Field positions
// *****
`define SCP_CMD_SOFTRST    5
`define SCP_CMD_STANDBY    4
`define SCP_MOTOR_EN       4
`define SCP_SENSE1_HALT    0
`define SCP_SENSE2_HALT    1
`define SCP_MODE_PIXCOLOR  0

// *****
// Command codes
// *****
`define SCP_CMD_FWD        4'h1
`define SCP_CMD_REV        4'h2
`define SCP_CMD_PFWD       4'h4
`define SCP_CMD_PREV       4'h5

// *****
// Reset values
// *****
`define SCP_RST_CMD        8'h30
`define SCP_RST_MDIV       6'h00
`define SCP_RST_STRETCH    8'h00
`define SCP_RST_MOTOR      8'h00
`define SCP_RST_FF         16'h0010
`define SCP_RST_CNT        16'h0000
`define SCP_RST_SENSE      8'h00
`define SCP_RST_TRAIL      16'h0000
`define SCP_RST_MODE       8'h00
`define SCP_RST_LLEN       16'h0100
`define SCP_RST_MISC       8'h00

// *****
// Timing
// *****
`define SCP_CLK_HZ         20000000
`define SCP_SUSPEND_US     3000
`define SCP_SUSPEND_CYC    (`SCP_SUSPEND_US * (`SCP_CLK_HZ / 1000000))
`define SCP_PIX_CYC_PER_HALF 10'h004

`endif

// >>> design/scp_half_divider.v
`timescale 1ns/1ns
`include "scp_consts.vh"

// Divides the oscillator by (code+2)/2 using a half-step accumulator
module scp_half_divider
(
   // Clock and reset
   input  wire       mclk,
   input  wire       rst_n,
   // Control
   input  wire       run,
   input  wire [5:0] code,
   // Divided output
   output reg        tick,
   output reg        master_clk
);

   reg  [6:0] acc;
   wire [6:0] limit  = {1'b0, code} + 7'h02;
   wire [6:0] summed = acc + 7'h02;

   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc        <= 7'h00;
         tick       <= 1'b0;
         master_clk <= 1'b0;
      end
      else if (!run)
      begin
         acc  <= 7'h00;
         tick <= 1'b0;
      end
      else if (summed >= limit) // RULE7
      begin
         // Odd codes alternate n and n+1 cycles: average is exact half step
         acc        <= summed - limit;
         tick       <= 1'b1;
         master_clk <= ~master_clk;
      end
      else
      begin
         acc  <= summed;
         tick <= 1'b0;
      end
   end

endmodule // scp_half_divider

// >>> design/scp_command_power.v
`timescale 1ns/1ns
`include "scp_consts.vh"

//Function
// (RULE1) Command 1 drives motor forward fast
// (RULE2) Fast move stops on 0 or sense
// (RULE3) Forward sense2 trip adds trailing steps
// (RULE4) Programmed moves stop after line count
// (RULE5) Command 2 drives motor backward fast
// (RULE6) Reverse ignores sense2 trailing steps
// (RULE7) Master clock divides by half steps
// (RULE8) Most logic on divided master clock; code clocks all logic by mclk, only step timer counts master ticks
// (RULE9) Reset pin pulse gives power-on reset
// (RULE10) Power-on reset loads register defaults
// (RULE11) Power-on reset clears USB state
// (RULE12) Spare 1-3 inputs, 4-6 outputs
// (RULE13) Soft reset bit stops clocks, machines
// (RULE14) Soft reset stops DRAM refresh
// (RULE15) Registers stay accessible in soft reset
// (RULE16) Standby powers down analog, motor hi-Z
// (RULE17) Bus idle 3ms enters suspend
// (RULE18) Suspended spare inputs raise wakeup
// (RULE19) Suspend exit keeps reset bits set
// (RULE20) Pixel period from divider, colour, 8
// (RULE21) Line time is (1+stretch) times integration
// (RULE22) Host keeps pixel rate legal
// (RULE23) Host loads tables only when idle
// (RULE24) Motion field decoded apart from power bits
module scp_command_power
#(
   parameter SUSPEND_CYC = `SCP_SUSPEND_CYC
)
(
   // Clock and reset
   input  wire        mclk,
   input  wire        rst_n,
   // Register port
   input  wire [7:0]  addr,
   input  wire [7:0]  wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [7:0]  rdata,
   // External pins
   input  wire        reset_pin,
   input  wire        usb_activity,
   input  wire        sense1,
   input  wire        sense2,
   input  wire [2:0]  misc_in,
   output reg  [2:0]  misc_out,
   // Motor
   output reg         motor_step,
   output reg         motor_dir,
   output wire        motor_oe_n,
   // Power and clocks
   output wire        master_clk,
   output wire        master_tick,
   output wire        osc_run,
   output wire        core_clk_en,
   output wire        dram_refresh_en,
   output wire        analog_pd,
   output reg         usb_reset,
   output reg         remote_wakeup,
   output reg         line_pulse
);

   // *****
   // State encodings
   // *****
   localparam [3:0] ST_IDLE  = 4'b0001;
   localparam [3:0] ST_RUN   = 4'b0010;
   localparam [3:0] ST_TRAIL = 4'b0100;
   localparam [3:0] ST_HALT  = 4'b1000;

   // *****
   // Input synchronisers
   // *****
   reg [6:0] sync1;
   reg [6:0] sync2;
   reg [6:0] sync3;
   reg [6:0] clean;
   wire [6:0] raw_in = {misc_in, usb_activity, reset_pin, sense2, sense1};
   integer i;

   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1 <= 7'h00;
         sync2 <= 7'h00;
         sync3 <= 7'h00;
         clean <= 7'h00;
      end
      else
      begin
         sync1 <= raw_in;
         sync2 <= sync1;
         sync3 <= sync2;
         for (i = 0; i < 7; i = i + 1)
            if (sync2[i] == sync3[i])
               clean[i] <= sync3[i];
      end
   end

   wire       s1_in   = clean[0];
   wire       s2_in   = clean[1];
   wire       rpin_in = clean[2];
   wire       act_in  = clean[3];
   wire [2:0] spare_in = clean[6:4];

   // *****
   // Reset pin pulse and suspend timer
   // *****
   reg        rpin_seen;
   reg        por;
   reg        suspended;
   reg        act_prev;
   reg [31:0] idle_cnt;
   wire       activity_edge = act_in ^ act_prev;

   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rpin_seen <= 1'b0;
         por       <= 1'b1;
         suspended <= 1'b0;
         act_prev  <= 1'b0;
         idle_cnt  <= 32'h00000000;
      end
      else
      begin
         act_prev <= act_in;
         // Low-high-low completes on the falling edge
         rpin_seen <= rpin_in ? 1'b1 : 1'b0;
         por       <= rpin_seen & ~rpin_in; // RULE9
         if (activity_edge || por)
         begin
            idle_cnt  <= 32'h00000000;
            suspended <= 1'b0; // RULE19
         end
         else if (idle_cnt >= SUSPEND_CYC - 1)
            suspended <= 1'b1; // RULE17
         else
            idle_cnt <= idle_cnt + 32'h00000001;
      end
   end

   // *****
   // Configuration registers
   // *****
   reg [7:0]  cmd_reg;
   reg [5:0]  mdiv;
   reg [7:0]  stretch;
   reg [7:0]  motor_cfg;
   reg [15:0] ff_step;
   reg [15:0] line_cnt_cfg;
   reg [7:0]  sense_cfg;
   reg [15:0] trail_cfg;
   reg [7:0]  mode_cfg;
   reg [15:0] line_len;
   reg        initialized;
   reg        start_req;
   reg [2:0]  sync_spare_q;
   wire       wr_cmd = wr && (addr == `SCP_REG_CMD);
   wire       defaults = por || suspended;

   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmd_reg      <= `SCP_RST_CMD;
         mdiv         <= `SCP_RST_MDIV;
         stretch      <= `SCP_RST_STRETCH;
         motor_cfg    <= `SCP_RST_MOTOR;
         ff_step      <= `SCP_RST_FF;
         line_cnt_cfg <= `SCP_RST_CNT;
         sense_cfg    <= `SCP_RST_SENSE;
         trail_cfg    <= `SCP_RST_TRAIL;
         mode_cfg     <= `SCP_RST_MODE;
         line_len     <= `SCP_RST_LLEN;
         misc_out     <= 3'h0;
         initialized  <= 1'b0;
         start_req    <= 1'b0;
      end
      else if (defaults)
      begin
         // Suspend holds defaults, so soft reset and standby read set on exit
         cmd_reg      <= `SCP_RST_CMD; // RULE10 RULE17 RULE19
         mdiv         <= `SCP_RST_MDIV;
         stretch      <= `SCP_RST_STRETCH;
         motor_cfg    <= `SCP_RST_MOTOR;
         ff_step      <= `SCP_RST_FF;
         line_cnt_cfg <= `SCP_RST_CNT;
         sense_cfg    <= `SCP_RST_SENSE;
         trail_cfg    <= `SCP_RST_TRAIL;
         mode_cfg     <= `SCP_RST_MODE;
         line_len     <= `SCP_RST_LLEN;
         misc_out     <= 3'h0; // RULE12
         // Suspend keeps it, so a configured device can still wake the host
         initialized  <= initialized & ~por;
         start_req    <= 1'b0;
      end
      else
      begin
         start_req <= wr_cmd;
         if (wr) // RULE15
         begin
            initialized <= 1'b1;
            case (addr)
               `SCP_REG_CMD:      cmd_reg            <= wdata;
               `SCP_REG_MDIV:     mdiv               <= wdata[5:0];
               `SCP_REG_STRETCH:  stretch            <= wdata;
               `SCP_REG_MOTOR:    motor_cfg          <= wdata;
               `SCP_REG_FF_LO:    ff_step[7:0]       <= wdata;
               `SCP_REG_FF_HI:    ff_step[15:8]      <= wdata;
               `SCP_REG_CNT_LO:   line_cnt_cfg[7:0]  <= wdata;
               `SCP_REG_CNT_HI:   line_cnt_cfg[15:8] <= wdata;
               `SCP_REG_SENSE:    sense_cfg          <= wdata;
               `SCP_REG_TRAIL_LO: trail_cfg[7:0]     <= wdata;
               `SCP_REG_TRAIL_HI: trail_cfg[15:8]    <= wdata;
               `SCP_REG_MODE:     mode_cfg           <= wdata;
               `SCP_REG_LLEN_LO:  line_len[7:0]      <= wdata;
               `SCP_REG_LLEN_HI:  line_len[15:8]     <= wdata;
               `SCP_REG_MISC:     misc_out           <= wdata[2:0]; // RULE12
               default:           initialized        <= 1'b1;
            endcase
         end
      end
   end

   // Motion code kept apart from the power bits
   wire [3:0] motion_code = cmd_reg[3:0]; // RULE24
   wire       soft_rst    = cmd_reg[`SCP_CMD_SOFTRST];
   wire       standby     = cmd_reg[`SCP_CMD_STANDBY];

   // *****
   // Master clock and power outputs
   // *****
   assign osc_run         = ~suspended;
   assign core_clk_en     = ~soft_rst & ~suspended; // RULE13
   assign dram_refresh_en = ~soft_rst & ~suspended; // RULE14
   assign analog_pd       = standby | suspended; // RULE16

   scp_half_divider u_div // RULE8
   (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .run        (core_clk_en),
      .code       (mdiv),
      .tick       (master_tick),
      .master_clk (master_clk)
   );

   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         usb_reset     <= 1'b1;
         remote_wakeup <= 1'b0;
      end
      else
      begin
         usb_reset     <= por; // RULE11
         // Only an initialized, suspended device may wake the host
         remote_wakeup <= suspended && initialized && (|(spare_in ^ sync_spare_q)); // RULE18
      end
   end

   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         sync_spare_q <= 3'h0;
      else
         sync_spare_q <= spare_in;
   end

   // *****
   // Motion state machine (mclk; steps timed in master clock ticks)
   // *****
   reg [3:0]  state;
   reg [15:0] step_timer;
   reg [15:0] steps_done;
   reg [15:0] trail_left;
   reg        halted_sense;
   wire       is_fwd  = (motion_code == `SCP_CMD_FWD) || (motion_code == `SCP_CMD_PFWD);
   wire       is_rev  = (motion_code == `SCP_CMD_REV) || (motion_code == `SCP_CMD_PREV);
   wire       is_prog = (motion_code == `SCP_CMD_PFWD) || (motion_code == `SCP_CMD_PREV);
   wire       s1_halt = s1_in && sense_cfg[`SCP_SENSE1_HALT];
   wire       s2_halt = s2_in && sense_cfg[`SCP_SENSE2_HALT];
   wire       step_due = master_tick && (step_timer == 16'h0000);

   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state        <= ST_IDLE;
         step_timer   <= 16'h0000;
         steps_done   <= 16'h0000;
         trail_left   <= 16'h0000;
         motor_step   <= 1'b0;
         motor_dir    <= 1'b0;
         halted_sense <= 1'b0;
      end
      else if (soft_rst || defaults) // RULE13
      begin
         state      <= ST_IDLE;
         step_timer <= 16'h0000;
         steps_done <= 16'h0000;
         trail_left <= 16'h0000;
         motor_step <= 1'b0;
      end
      else
      begin
         motor_step <= 1'b0;
         if (master_tick && step_timer != 16'h0000)
            step_timer <= step_timer - 16'h0001;
         case (state)
            ST_IDLE:
            begin
               if (is_fwd || is_rev) // RULE1 RULE5
               begin
                  state        <= ST_RUN;
                  motor_dir    <= is_rev;
                  step_timer   <= ff_step;
                  steps_done   <= 16'h0000;
                  halted_sense <= 1'b0;
               end
            end
            ST_RUN:
            begin
               if (!(is_fwd || is_rev))
                  state <= ST_IDLE; // RULE2
               else if (s1_halt || (s2_halt && (is_rev || trail_cfg == 16'h0000)))
               begin
                  state        <= ST_HALT; // RULE2 RULE6
                  halted_sense <= 1'b1;
               end
               else if (s2_halt)
               begin
                  state      <= ST_TRAIL; // RULE3
                  trail_left <= trail_cfg;
               end
               else if (is_prog && steps_done >= line_cnt_cfg)
                  state <= ST_HALT; // RULE4
               else if (step_due)
               begin
                  motor_step <= 1'b1;
                  step_timer <= ff_step;
                  steps_done <= steps_done + 16'h0001;
               end
            end
            ST_TRAIL:
            begin
               if (!is_fwd)
                  state <= ST_IDLE;
               else if (trail_left == 16'h0000)
               begin
                  state        <= ST_HALT; // RULE3
                  halted_sense <= 1'b1;
               end
               else if (step_due)
               begin
                  motor_step <= 1'b1;
                  step_timer <= ff_step;
                  trail_left <= trail_left - 16'h0001;
               end
            end
            ST_HALT:
            begin
               // Stays stopped until a new command is written
               if (start_req)
                  state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Standby floats the motor regardless of the enable bit
   assign motor_oe_n = ~(motor_cfg[`SCP_MOTOR_EN] && !standby && !suspended); // RULE16

   // *****
   // Pixel and line timing
   // *****
   function [9:0] pix_cycles;
      input [5:0] code;
      input       pix_color;
      reg   [9:0] half;
      begin
         half = {4'h0, code} + 10'h002;
         // (code+2)/2 * C * 8 = (code+2) * C * 4
         pix_cycles = (pix_color ? half * 10'h003 : half) * `SCP_PIX_CYC_PER_HALF;
      end
   endfunction

   wire [9:0]  pix_per = pix_cycles(mdiv, mode_cfg[`SCP_MODE_PIXCOLOR]); // RULE20
   wire [24:0] line_units = {9'h000, line_len} * ({17'h00000, stretch} + 25'h0000001); // RULE21
   reg  [9:0]  pix_cnt;
   reg  [24:0] unit_cnt;

   // Runs on the oscillator, not the divided clock, so cycles count exactly
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pix_cnt    <= 10'h000;
         unit_cnt   <= 25'h0000000;
         line_pulse <= 1'b0;
      end
      else if (!core_clk_en)
      begin
         pix_cnt    <= 10'h000;
         unit_cnt   <= 25'h0000000;
         line_pulse <= 1'b0;
      end
      else
      begin
         line_pulse <= 1'b0;
         if (pix_cnt >= pix_per - 10'h001)
         begin
            pix_cnt <= 10'h000;
            if (unit_cnt >= line_units - 25'h0000001) // RULE21
            begin
               unit_cnt   <= 25'h0000000;
               line_pulse <= 1'b1;
            end
            else
               unit_cnt <= unit_cnt + 25'h0000001;
         end
         else
            pix_cnt <= pix_cnt + 10'h001;
      end
   end

   // *****
   // Read port
   // *****
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= 8'h00;
      else if (rd)
      begin
         case (addr)
            `SCP_REG_CMD:      rdata <= cmd_reg;
            `SCP_REG_MDIV:     rdata <= {2'b00, mdiv};
            `SCP_REG_STRETCH:  rdata <= stretch;
            `SCP_REG_MOTOR:    rdata <= motor_cfg;
            `SCP_REG_FF_LO:    rdata <= ff_step[7:0];
            `SCP_REG_FF_HI:    rdata <= ff_step[15:8];
            `SCP_REG_CNT_LO:   rdata <= line_cnt_cfg[7:0];
            `SCP_REG_CNT_HI:   rdata <= line_cnt_cfg[15:8];
            `SCP_REG_SENSE:    rdata <= sense_cfg;
            `SCP_REG_TRAIL_LO: rdata <= trail_cfg[7:0];
            `SCP_REG_TRAIL_HI: rdata <= trail_cfg[15:8];
            `SCP_REG_MODE:     rdata <= mode_cfg;
            `SCP_REG_LLEN_LO:  rdata <= line_len[7:0];
            `SCP_REG_LLEN_HI:  rdata <= line_len[15:8];
            `SCP_REG_MISC:     rdata <= {5'h00, misc_out};
            `SCP_REG_STATUS:   rdata <= {suspended, halted_sense, motor_dir, spare_in, s2_in, s1_in};
            `SCP_REG_PPER_LO:  rdata <= pix_per[7:0];
            `SCP_REG_PPER_HI:  rdata <= {6'h00, pix_per[9:8]};
            default:           rdata <= 8'h00;
         endcase
      end
      else
         rdata <= 8'h00;
   end

endmodule // scp_command_power

// >>> testbench/scp_host_model.sv
`timescale 1ns/1ns

// Host bus traffic and a sheet that reaches the second sensor after some steps
module scp_host_model
(
   // Clock
   input  wire       mclk,
   // Bus side
   input  wire       awake,
   output reg        usb_activity,
   // Sheet path
   input  wire       arm,
   input  wire [7:0] trip_at,
   input  wire       motor_step,
   output wire       sense2
);
   reg [7:0] n_seen = 8'h00;
   reg [2:0] gap = 3'h0;

   initial
      usb_activity = 1'b0;

   always @(posedge mclk)
   begin
      gap <= gap + 3'h1;
      // Keeps the bus busy while awake is high, so the device does not idle into suspend
      if (awake && gap == 3'h7)
         usb_activity <= ~usb_activity;
      if (!arm)
         n_seen <= 8'h00;
      else if (motor_step === 1'b1 && n_seen != trip_at)
         n_seen <= n_seen + 8'h01;
   end

   // Sheet edge stays under the sensor until disarmed
   assign sense2 = arm && (n_seen == trip_at);
endmodule // scp_host_model

// >>> testbench/scp_cp_monitor.sv
`timescale 1ns/1ns
`include "scp_consts.vh"

module scp_cp_monitor
#(
   parameter SUSPEND_CYC = 50
)
(
   // Clock and reset
   input wire       mclk,
   input wire       rst_n,
   // Register port
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire       wr,
   input wire       rd,
   input wire [7:0] rdata,
   // Pins and power
   input wire       usb_activity,
   input wire [2:0] misc_out,
   input wire       motor_step,
   input wire       motor_dir,
   input wire       motor_oe_n,
   input wire       osc_run,
   input wire       core_clk_en,
   input wire       dram_refresh_en,
   input wire       analog_pd,
   input wire       remote_wakeup
);
   integer idle_cnt;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // Raw bus idle time; the device sees it a few cycles late
   always @(posedge mclk or negedge rst_n)
      if (!rst_n)
         idle_cnt <= 0;
      else if ($changed(usb_activity))
         idle_cnt <= 0;
      else if (idle_cnt < 4000)
         idle_cnt <= idle_cnt + 1;

   property p_hiz; analog_pd |-> motor_oe_n; endproperty
   a_hiz: assert property (p_hiz) else $error("motor driven in low power");
   property p_susp; !osc_run |-> analog_pd && !core_clk_en && !dram_refresh_en; endproperty
   a_susp: assert property (p_susp) else $error("suspend left logic running");
   property p_refresh; core_clk_en == dram_refresh_en; endproperty
   a_refresh: assert property (p_refresh) else $error("refresh not tied to soft reset");
   property p_step; motor_step |=> !motor_step [*2]; endproperty
   a_step: assert property (p_step) else $error("steps too close");
   property p_dir; motor_step |-> $stable(motor_dir); endproperty
   a_dir: assert property (p_dir) else $error("direction moved at a step");
   property p_late; idle_cnt > SUSPEND_CYC + 16 |-> !osc_run; endproperty
   a_late: assert property (p_late) else $error("suspend not entered");
   property p_early; $fell(osc_run) |-> idle_cnt >= SUSPEND_CYC; endproperty
   a_early: assert property (p_early) else $error("suspend too early");
   property p_hold; osc_run && $changed(usb_activity) && idle_cnt < SUSPEND_CYC - 8 |=> osc_run [*8]; endproperty
   a_hold: assert property (p_hold) else $error("suspend despite activity");
   property p_misc; wr && addr == `SCP_REG_MISC && osc_run |=> misc_out == $past(wdata[2:0]); endproperty
   a_misc: assert property (p_misc) else $error("spare outputs not loaded");
   property p_wake; remote_wakeup |-> !osc_run || !$past(osc_run); endproperty
   a_wake: assert property (p_wake) else $error("wakeup while awake");
   property p_rdsr; rd && addr == `SCP_REG_CMD && !core_clk_en && osc_run |=> rdata[5]; endproperty
   a_rdsr: assert property (p_rdsr) else $error("soft reset bit not readable");
   property p_rdz; !rd |=> rdata == 8'h00; endproperty
   a_rdz: assert property (p_rdz) else $error("read data held too long");

   c_step: cover property (motor_step && motor_dir);
   c_susp: cover property ($fell(osc_run));
   c_srd: cover property (rd && !core_clk_en);
endmodule // scp_cp_monitor

bind scp_command_power scp_cp_monitor #(.SUSPEND_CYC(SUSPEND_CYC)) i_mon (.*);

// >>> testbench/testbench.sv
`timescale 1ns/1ns
`include "scp_consts.vh"

module testbench;
   reg        mclk = 1'b0;
   reg        rst_n = 1'b0;
   reg  [7:0] addr = 8'h00;
   reg  [7:0] wdata = 8'h00;
   reg        wr = 1'b0;
   reg        rd = 1'b0;
   reg        reset_pin = 1'b0;
   reg  [2:0] misc_in = 3'h0;
   reg        awake = 1'b1;
   reg        arm = 1'b0;
   reg        rd_q = 1'b0;
   reg  [7:0] exp_q [$];
   wire [7:0] rdata;
   wire [2:0] misc_out;
   wire       usb_activity, sense2, motor_step, motor_dir, motor_oe_n, master_clk, master_tick;
   wire       osc_run, core_clk_en, dram_refresh_en, analog_pd, usb_reset, remote_wakeup, line_pulse;
   integer    n_mismatch = 0;
   integer    checks_done = 0;
   integer    seed = 74754;
   integer    n_step = 0;
   integer    n_tick = 0;
   integer    n0, i, k, p;

   always #25 mclk = ~mclk;

   // Short idle limit keeps suspend tests brief
   scp_command_power #(.SUSPEND_CYC(50)) i_dut (.sense1(1'b0), .*);

   scp_host_model i_host (.trip_at(8'h03), .*);

   task chk(input [15:0] seen, input [15:0] want);
      begin
         checks_done = checks_done + 1;
         if (seen !== want)
         begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: seen %h want %h", $time, seen, want);
         end
      end
   endtask

   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", checks_done, n_mismatch);
         if (n_mismatch == 0 && checks_done > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask

   task wr_reg(input [7:0] a, input [7:0] d);
      begin
         @(posedge mclk);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge mclk);
         wr <= 1'b0;
      end
   endtask

   task rd_reg(input [7:0] a, input [7:0] e);
      begin
         @(posedge mclk);
         exp_q.push_back(e);
         addr <= a;
         rd <= 1'b1;
         @(posedge mclk);
         rd <= 1'b0;
      end
   endtask

   task run(input integer c);
      repeat (c) @(negedge mclk);
   endtask

   // Bounded wait: 0 step, 1 master tick, 2 line, 3 second sensor
   task wait_hi(input integer w);
      integer t;
      begin
         t = 0;
         do
         begin
            @(negedge mclk);
            t = t + 1;
         end while (!(w == 0 ? motor_step : w == 1 ? master_tick : w == 2 ? line_pulse : sense2) && t < 3000);
      end
   endtask

   // *****
   // Result watcher
   // *****
   always @(posedge mclk)
   begin
      if (motor_step === 1'b1)
         n_step <= n_step + 1;
      if (master_tick === 1'b1)
         n_tick <= n_tick + 1;
      rd_q <= rd;
      if (rd_q)
         chk(rdata, exp_q.pop_front());
   end

   initial
   begin
      #1000000;
      n_mismatch = n_mismatch + 1;
      print_verdict;
   end

   // *****
   // Scenarios
   // *****
   initial
   begin
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      rd_reg(`SCP_REG_CMD, `SCP_RST_CMD);
      rd_reg(`SCP_REG_LLEN_HI, 8'h01);
      rd_reg(8'h3F, 8'h00);
      run(2);
      chk({analog_pd, motor_oe_n, core_clk_en}, 3'b110);
      chk(dram_refresh_en, 1'b0);
      $display("test defaults done");
      wr_reg(`SCP_REG_MOTOR, 8'h10);
      wr_reg(`SCP_REG_FF_LO, 8'h04);
      wr_reg(`SCP_REG_FF_HI, 8'h00);
      for (k = 1; k <= 2; k = k + 1)
      begin
         wr_reg(`SCP_REG_CMD, k[7:0]);
         wait_hi(0);
         n0 = n_step;
         run(50);
         chk(n_step - n0, 10);
         chk({motor_dir, motor_oe_n}, {k == 2, 1'b0});
         wr_reg(`SCP_REG_CMD, 8'h00);
         run(8);
         n0 = n_step;
         run(60);
         chk(n_step - n0, 0);
      end
      wr_reg(`SCP_REG_CNT_LO, 8'h03);
      for (k = 4; k <= 5; k = k + 1)
      begin
         n0 = n_step;
         wr_reg(`SCP_REG_CMD, k[7:0]);
         run(80);
         chk(n_step - n0, 3);
         chk(motor_dir, k == 5);
      end
      wr_reg(`SCP_REG_SENSE, 8'h02);
      wr_reg(`SCP_REG_TRAIL_LO, 8'h02);
      for (k = 1; k <= 2; k = k + 1)
      begin
         wr_reg(`SCP_REG_CMD, k[7:0]);
         arm <= 1'b1;
         wait_hi(3);
         n0 = n_step;
         run(80);
         // One step leaves while the trip crosses the synchroniser
         chk(n_step - n0, k == 1 ? 3 : 1);
         wr_reg(`SCP_REG_CMD, 8'h00);
         arm <= 1'b0;
         run(8);
      end
      $display("test motion done");
      wr_reg(`SCP_REG_CMD, 8'h21);
      run(3);
      chk({core_clk_en, dram_refresh_en}, 2'b00);
      rd_reg(`SCP_REG_CMD, 8'h21);
      wr_reg(`SCP_REG_MISC, 8'h05);
      run(2);
      chk(misc_out, 3'h5);
      wr_reg(`SCP_REG_CMD, 8'h11);
      run(3);
      chk({analog_pd, motor_oe_n}, 2'b11);
      wr_reg(`SCP_REG_CMD, 8'h00);
      $display("test power bits done");
      i = $random(seed);
      wr_reg(`SCP_REG_MDIV, {2'b00, i[5:0]});
      wr_reg(`SCP_REG_MODE, 8'h01);
      p = (i[5:0] + 2) * 12;
      wait_hi(1);
      n0 = n_tick;
      run((i[5:0] + 2) * 10);
      chk(n_tick - n0, 20);
      rd_reg(`SCP_REG_PPER_LO, p[7:0]);
      rd_reg(`SCP_REG_PPER_HI, p[15:8]);
      wr_reg(`SCP_REG_MDIV, 8'h00);
      wr_reg(`SCP_REG_MODE, 8'h00);
      wr_reg(`SCP_REG_LLEN_HI, 8'h00);
      wr_reg(`SCP_REG_LLEN_LO, 8'h04);
      wr_reg(`SCP_REG_STRETCH, 8'h02);
      wait_hi(2);
      wait_hi(2);
      n0 = $time;
      wait_hi(2);
      chk(($time - n0) / 50, 96);
      $display("test clocks done");
      i = $random(seed);
      wr_reg(`SCP_REG_MISC, i[7:0]);
      misc_in <= i[5:3];
      run(2);
      chk(misc_out, i[2:0]);
      awake <= 1'b0;
      run(80);
      chk({osc_run, analog_pd, misc_out}, 5'h08);
      wr_reg(`SCP_REG_MISC, 8'h07);
      misc_in <= ~misc_in;
      k = 0;
      repeat (10)
      begin
         @(negedge mclk);
         if (remote_wakeup === 1'b1)
            k = 1;
      end
      chk(k, 1);
      awake <= 1'b1;
      run(20);
      chk({osc_run, misc_out}, 4'h8);
      rd_reg(`SCP_REG_CMD, `SCP_RST_CMD);
      wr_reg(`SCP_REG_CMD, 8'h00);
      $display("test suspend done");
      wr_reg(`SCP_REG_MISC, 8'h07);
      reset_pin <= 1'b1;
      run(4);
      @(posedge mclk);
      reset_pin <= 1'b0;
      k = 0;
      repeat (12)
      begin
         @(negedge mclk);
         if (usb_reset === 1'b1)
            k = 1;
      end
      chk(k, 1);
      chk(misc_out, 3'h0);
      rd_reg(`SCP_REG_CMD, `SCP_RST_CMD);
      run(2);
      $display("test pin reset done");
      print_verdict;
   end
endmodule // testbench
